// File: rtl/ilic_pkg.sv
// Shared constants and types for the instruction cache control block.
// Assumes a 32-bit virtual address and a single core clock.
package ilic_pkg;

  // ************************************************************
  // Geometry
  // ************************************************************
  localparam int SETS = 32;          // Sets in the cache
  localparam int WAYS = 32;          // Ways in each set
  localparam int WORDS = 8;          // Words in one line
  localparam int SET_W = 5;          // Set index width
  localparam int WAY_W = 5;          // Way number width
  localparam int TAG_W = 22;         // Virtual tag width
  localparam int WORD_W = 32;        // Instruction word width
  localparam int LINE_W = 256;       // Line width in bits
  localparam int ADDR_W = 32;        // Address width
  localparam int SET_LO = 5;         // Lowest set index bit
  localparam int TAG_LO = 10;        // Lowest tag bit
  localparam int LADDR_W = 27;       // Line address width

  // ************************************************************
  // Control values
  // ************************************************************
  localparam int EN_BIT = 12;                 // Enable bit of control reg
  localparam logic [4:0] LOCK_MAX = 5'h1C;    // Lockable ways per set
  localparam logic [4:0] RR_RESET = 5'h1F;    // Pointer after reset
  localparam logic [4:0] WAY_ONE = 5'h01;     // Pointer step
  localparam logic [2:0] LAST_WORD = 3'h7;    // Final word of a line
  localparam logic [2:0] WORD_ONE = 3'h1;     // Word counter step
  localparam logic [4:0] LINE_OFS = 5'h00;    // Byte offset of a line

  // Cache maintenance commands from the core
  typedef enum logic [1:0] {
    CMD_INV_ALL,
    CMD_INV_LINE,
    CMD_LOCK_LINE,
    CMD_UNLOCK_ALL
  } ilic_cmd_t;

endpackage

// File: rtl/ilic_fill_if.sv
// Link between the control block and its line fetch engine.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface ilic_fill_if;
  import ilic_pkg::*;
  logic start;                      // One-cycle request for a line
  logic [LADDR_W-1:0] line_addr;    // Line address, bits 31:5
  logic done;                       // One-cycle pulse, line complete
  logic [LINE_W-1:0] line;          // Gathered line, word 0 lowest

  modport ctrl (output start, output line_addr, input done, input line);
  modport fetch (input start, input line_addr, output done, output line);
endinterface

// File: rtl/ilic_line_fetch.sv
// Line fetch engine: reads one whole line from external memory.
// Assumes memory returns exactly eight words after each request.
`timescale 1ns/1ps
module ilic_line_fetch
  import ilic_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  ilic_fill_if.fetch fill,
  output logic mem_req,
  output logic [ADDR_W-1:0] mem_addr,
  input wire logic mem_word_valid,
  input wire logic [WORD_W-1:0] mem_word
);
  import ilic_pkg::*;

  // ************************************************************
  // State
  // ************************************************************
  typedef enum {FS_IDLE, FS_COLLECT} ilic_fs_t;

  typedef struct packed {
    ilic_fs_t st;                           // Engine state
    logic [2:0] cnt;                        // Next word slot
    logic req;                              // Memory request pulse
    logic [ADDR_W-1:0] addr;                // Line start address
    logic [WORDS-1:0][WORD_W-1:0] line;     // Gathered words
    logic done;                             // Completion pulse
  } ilic_fetch_state_t;

  ilic_fetch_state_t q, d;

  // Next state: request, then collect in order
  always_comb begin
    d = q;
    d.req = 1'b0;
    d.done = 1'b0;
    case (q.st)
      FS_IDLE: begin
        if (fill.start) begin
          d.req = 1'b1;
          d.addr = {fill.line_addr, LINE_OFS};
          d.cnt = '0;
          d.st = FS_COLLECT;
        end
      end
      FS_COLLECT: begin
        // Words land in sequence; the line is only used when complete
        if (mem_word_valid) begin
          d.line[q.cnt] = mem_word;
          d.cnt = q.cnt + WORD_ONE;
          if (q.cnt == LAST_WORD) begin
            d.done = 1'b1;
            d.st = FS_IDLE;
          end
        end
      end
      default: begin
        d.st = FS_IDLE;
      end
    endcase
  end

  // Register the state
  always_ff @(posedge clock) begin
    if (rst) begin
      q <= '0;
      q.st <= FS_IDLE;
    end else begin
      q <= d;
    end
  end

  assign fill.done = q.done;
  assign fill.line = q.line;
  assign mem_req = q.req;
  assign mem_addr = q.addr;
endmodule

// File: rtl/ilic_top.sv
// Instruction cache control: enable, invalidation, locking and the
// per-set round-robin replacement pointers, with valid, lock and tag
// state for every line. Assumes the data RAM, fetch buffers and the
// branch predictor sit outside and obey the strobes driven here.
`timescale 1ns/1ps
module ilic_top
  import ilic_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic ctrl_wr,
  input wire logic [ADDR_W-1:0] ctrl_wdata,
  input wire logic cmd_valid,
  input wire ilic_pkg::ilic_cmd_t cmd_code,
  input wire logic [ADDR_W-1:0] cmd_addr,
  output logic cmd_ready,
  output logic cmd_done,
  input wire logic fb_wr_valid,
  input wire logic fb_cacheable,
  input wire logic [ADDR_W-1:0] fb_addr,
  input wire logic [LINE_W-1:0] fb_line,
  input wire logic [ADDR_W-1:0] lookup_addr,
  output logic lookup_hit,
  output logic [WAY_W-1:0] lookup_way,
  output logic icache_enable,
  output logic fetch_buf_flush,
  output logic branch_predict_buffer_inv,
  output logic line_wr_valid,
  output logic [SET_W-1:0] line_wr_set,
  output logic [WAY_W-1:0] line_wr_way,
  output logic [LINE_W-1:0] line_wr_data,
  output logic mem_req,
  output logic [ADDR_W-1:0] mem_addr,
  input wire logic mem_word_valid,
  input wire logic [WORD_W-1:0] mem_word
);
  import ilic_pkg::*;

  // ************************************************************
  // Types and state
  // ************************************************************
  typedef enum {ST_IDLE, ST_EXEC, ST_LOCK_WAIT} ilic_st_t;

  typedef struct packed {
    ilic_st_t st;                               // Command sequencer
    logic idle;                                 // Ready for work
    logic enable;                               // Cache enable bit
    logic [SETS-1:0][WAYS-1:0][TAG_W-1:0] tag;  // Virtual tags
    logic [SETS-1:0][WAYS-1:0] valid;           // Line valid bits
    logic [SETS-1:0][WAYS-1:0] lock;            // Line lock bits
    logic [SETS-1:0][WAY_W-1:0] rr;             // Replacement pointers
    logic [SETS-1:0][WAY_W-1:0] lock_cnt;       // Locked ways per set
    ilic_cmd_t cmd;                             // Command in progress
    logic [ADDR_W-1:0] addr;                    // Its address
    logic done;                                 // Completion pulse
    logic fill_start;                           // Line fetch request
    logic fb_flush;                             // Fetch buffer flush
    logic bpb_inv;                              // Predictor flush
    logic wr_valid;                             // Data RAM write
    logic [SET_W-1:0] wr_set;                   // Its set
    logic [WAY_W-1:0] wr_way;                   // Its way
    logic [LINE_W-1:0] wr_data;                 // Its line
    logic hit;                                  // Lookup result
    logic [WAY_W-1:0] hit_way;                  // Way that hit
  } ilic_state_t;

  ilic_state_t q, d;

  ilic_fill_if fill ();

  logic [WAYS-1:0] look_m;       // Lookup match vector
  logic [WAYS-1:0] cmd_m;        // Command address match vector
  logic [SET_W-1:0] cs;          // Command set index
  logic [SET_W-1:0] fs;          // Fetch buffer set index
  logic [WAY_W-1:0] lw;          // Way chosen for a lock fill
  logic cmd_take;                // Command accepted this cycle
  logic fb_take;                 // Fetch buffer line accepted

  // ************************************************************
  // Decoding helpers
  // ************************************************************

  // Set index of a virtual address
  function automatic logic [SET_W-1:0] set_of(input logic [ADDR_W-1:0] a);
    set_of = a[SET_LO +: SET_W];
  endfunction

  // Virtual tag of an address
  function automatic logic [TAG_W-1:0] tag_of(input logic [ADDR_W-1:0] a);
    tag_of = a[TAG_LO +: TAG_W];
  endfunction

  // Ways of one set holding a valid line with this tag
  function automatic logic [WAYS-1:0] match(
    input logic [WAYS-1:0] v,
    input logic [WAYS-1:0][TAG_W-1:0] t,
    input logic [TAG_W-1:0] want
  );
    logic [WAYS-1:0] m;
    m = '0;
    for (int i = 0; i < WAYS; i++) begin
      m[i] = v[i] && (t[i] == want);
    end
    match = m;
  endfunction

  // Lowest set bit; tags are unique per set so one at most is set
  function automatic logic [WAY_W-1:0] first_one(input logic [WAYS-1:0] m);
    logic [WAY_W-1:0] w;
    w = '0;
    for (int i = WAYS - 1; i >= 0; i--) begin
      if (m[i]) begin
        w = WAY_W'(i);
      end
    end
    first_one = w;
  endfunction

  // Pointer after a write: past the way, wrapping above the locks
  function automatic logic [WAY_W-1:0] next_rr(
    input logic [WAY_W-1:0] rr,
    input logic [WAY_W-1:0] floor
  );
    next_rr = (rr == RR_RESET) ? floor : WAY_W'(rr + WAY_ONE);
  endfunction

  // ************************************************************
  // Line fetch engine
  // ************************************************************
  ilic_line_fetch u_fetch (
    .clock(clock),
    .rst(rst),
    .fill(fill.fetch),
    .mem_req(mem_req),
    .mem_addr(mem_addr),
    .mem_word_valid(mem_word_valid),
    .mem_word(mem_word)
  );

  assign fill.start = q.fill_start;
  assign fill.line_addr = q.addr[ADDR_W-1:SET_LO];

  // ************************************************************
  // Next state
  // ************************************************************

  // Fetch buffer writes take priority; commands wait for as long as fb_wr_valid is high
  assign fb_take = q.idle && fb_wr_valid;
  assign cmd_take = q.idle && cmd_valid && !fb_wr_valid;
  assign cs = set_of(q.addr);
  assign fs = set_of(fb_addr);

  // One process for every field; pulses default low each cycle
  always_comb begin
    look_m = match(q.valid[set_of(lookup_addr)], q.tag[set_of(lookup_addr)],
      tag_of(lookup_addr));
    cmd_m = match(q.valid[cs], q.tag[cs], tag_of(q.addr));
    lw = q.lock_cnt[cs];
    d = q;
    d.done = 1'b0;
    d.fill_start = 1'b0;
    d.fb_flush = 1'b0;
    d.bpb_inv = 1'b0;
    d.wr_valid = 1'b0;

    if (ctrl_wr) begin
      d.enable = ctrl_wdata[EN_BIT];
    end

    // Lookup result, one cycle after the address
    d.hit = |look_m;
    d.hit_way = first_one(look_m);

    case (q.st)
      ST_IDLE: begin
        // only fetch-buffer writes and commands change lines
        if (fb_take) begin
          if (fb_cacheable && q.enable) begin
            d.tag[fs][q.rr[fs]] = tag_of(fb_addr);
            d.valid[fs][q.rr[fs]] = 1'b1;
            d.rr[fs] = next_rr(q.rr[fs], q.lock_cnt[fs]);
            d.wr_valid = 1'b1;
            d.wr_set = fs;
            d.wr_way = q.rr[fs];
            d.wr_data = fb_line;
          end
        end else if (cmd_take) begin
          d.cmd = cmd_code;
          d.addr = cmd_addr;
          d.st = ST_EXEC;
        end
      end
      ST_EXEC: begin
        d.st = ST_IDLE;
        d.done = 1'b1;
        case (q.cmd)
          CMD_INV_ALL: begin
            for (int s = 0; s < SETS; s++) begin
              d.valid[s] = q.valid[s] & q.lock[s];
            end
            d.fb_flush = 1'b1;
            d.bpb_inv = 1'b1;
          end
          CMD_INV_LINE: begin
            // single line invalidate
            // Locked lines stay, keeping the lock run contiguous
            d.valid[cs] = q.valid[cs] & ~(cmd_m & ~q.lock[cs]);
            d.bpb_inv = 1'b1;
          end
          CMD_UNLOCK_ALL: begin
            d.lock = '0;
            d.lock_cnt = '0;
          end
          CMD_LOCK_LINE: begin
            // A line already present is left as it is
            if (!(|cmd_m)) begin
              d.fill_start = 1'b1;
              d.done = 1'b0;
              d.st = ST_LOCK_WAIT;
            end
          end
          default: begin
            d.st = ST_IDLE;
          end
        endcase
      end
      ST_LOCK_WAIT: begin
        // completion only after the fill lands
        if (fill.done) begin
          d.st = ST_IDLE;
          d.done = 1'b1;
          d.wr_valid = 1'b1;
          d.wr_set = cs;
          d.wr_data = fill.line;
          if (q.lock_cnt[cs] < LOCK_MAX) begin
            d.tag[cs][lw] = tag_of(q.addr);
            d.valid[cs][lw] = 1'b1;
            d.lock[cs][lw] = 1'b1;
            d.lock_cnt[cs] = WAY_W'(lw + WAY_ONE);
            d.wr_way = lw;
            if (q.rr[cs] <= lw) begin
              d.rr[cs] = WAY_W'(lw + WAY_ONE);
            end
          end else begin
            d.tag[cs][q.rr[cs]] = tag_of(q.addr);
            d.valid[cs][q.rr[cs]] = 1'b1;
            d.wr_way = q.rr[cs];
            d.rr[cs] = next_rr(q.rr[cs], q.lock_cnt[cs]);
          end
        end
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase
    d.idle = (d.st == ST_IDLE);
  end

  // ************************************************************
  // State register
  // ************************************************************

  always_ff @(posedge clock) begin
    if (rst) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.idle <= 1'b1;
      q.rr <= {SETS{RR_RESET}};
    end else begin
      q <= d;
    end
  end

  // ************************************************************
  // Outputs, all straight from the state register
  // ************************************************************
  assign cmd_ready = q.idle;
  assign cmd_done = q.done;
  assign lookup_hit = q.hit;
  assign lookup_way = q.hit_way;
  assign icache_enable = q.enable;
  assign fetch_buf_flush = q.fb_flush;
  assign branch_predict_buffer_inv = q.bpb_inv;
  assign line_wr_valid = q.wr_valid;
  assign line_wr_set = q.wr_set;
  assign line_wr_way = q.wr_way;
  assign line_wr_data = q.wr_data;
endmodule

// File: verification/ilic_top_props.sv
// Port checker for the instruction cache control block.
// Assumes one core clock and a synchronous active-high reset.
`timescale 1ns/1ps
module ilic_top_props
  import ilic_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic ctrl_wr,
  input wire logic [ADDR_W-1:0] ctrl_wdata,
  input wire logic cmd_valid,
  input wire ilic_pkg::ilic_cmd_t cmd_code,
  input wire logic cmd_ready,
  input wire logic cmd_done,
  input wire logic fb_wr_valid,
  input wire logic fb_cacheable,
  input wire logic [ADDR_W-1:0] fb_addr,
  input wire logic [LINE_W-1:0] fb_line,
  input wire logic icache_enable,
  input wire logic fetch_buf_flush,
  input wire logic branch_predict_buffer_inv,
  input wire logic line_wr_valid,
  input wire logic [SET_W-1:0] line_wr_set,
  input wire logic [LINE_W-1:0] line_wr_data,
  input wire logic mem_req,
  input wire logic [ADDR_W-1:0] mem_addr
);
  import ilic_pkg::*;
  // ************************************************************
  // Acceptance terms
  // ************************************************************
  wire take = cmd_valid && cmd_ready && !fb_wr_valid; // Command taken
  wire fb_take = fb_wr_valid && cmd_ready; // Line taken, wins
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Lock request followed by fetch or quick done
  sequence s_lock_take;
    take && cmd_code == CMD_LOCK_LINE;
  endsequence
  sequence s_lock_answer;
    // A hit is done in two cycles; a miss requests memory one cycle later
    (##2 cmd_done) or (##3 mem_req);
  endsequence
  // ************************************************************
  // Assertions
  // ************************************************************
  a_reset_quiet: assert property ($fell(rst) |-> !icache_enable
    && cmd_ready && !cmd_done && !mem_req) else $error("reset state");
  a_enable_follow: assert property (ctrl_wr |=>
    icache_enable == $past(ctrl_wdata[EN_BIT])) else $error("enable");
  a_flush_all: assert property (take && cmd_code == CMD_INV_ALL |->
    ##2 (cmd_done && fetch_buf_flush && branch_predict_buffer_inv))
    else $error("invalidate all");
  a_flush_cause: assert property (fetch_buf_flush |->
    $past(take && cmd_code == CMD_INV_ALL, 2)) else $error("flush");
  a_line_inv: assert property (take && cmd_code == CMD_INV_LINE |->
    ##2 (cmd_done && branch_predict_buffer_inv && !fetch_buf_flush))
    else $error("line invalidate");
  a_unlock_keep: assert property (take && cmd_code == CMD_UNLOCK_ALL
    |-> ##2 (cmd_done && !fetch_buf_flush)) else $error("unlock");
  a_lock_start: assert property (s_lock_take |-> s_lock_answer)
    else $error("lock start");
  a_fill_end: assert property (mem_req |-> mem_addr[4:0] == 5'h00
    ##[9:400] (cmd_done && line_wr_valid)) else $error("line fill");
  a_fb_write: assert property (fb_take && fb_cacheable && icache_enable
    |=> line_wr_valid && line_wr_data == $past(fb_line)
    && line_wr_set == $past(fb_addr[9:5])) else $error("line write");
  a_fb_skip: assert property (fb_take && !(fb_cacheable
    && icache_enable) |=> !line_wr_valid) else $error("write gated");
  a_ready_drop: assert property (take |=> !cmd_ready)
    else $error("ready");
endmodule
bind ilic_top ilic_top_props u_props (.clock(clock), .rst(rst),
  .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .cmd_valid(cmd_valid),
  .cmd_code(cmd_code), .cmd_ready(cmd_ready), .cmd_done(cmd_done),
  .fb_wr_valid(fb_wr_valid), .fb_cacheable(fb_cacheable),
  .fb_addr(fb_addr), .fb_line(fb_line), .icache_enable(icache_enable),
  .fetch_buf_flush(fetch_buf_flush), .line_wr_valid(line_wr_valid),
  .branch_predict_buffer_inv(branch_predict_buffer_inv),
  .line_wr_set(line_wr_set), .line_wr_data(line_wr_data),
  .mem_req(mem_req), .mem_addr(mem_addr));

// File: verification/ilic_mem_model.sv
// External memory model: returns eight words per line request.
// Assumes requests arrive only while no line is in flight.
`timescale 1ns/1ps
module ilic_mem_model
  import ilic_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic slow,
  input wire logic mem_req,
  input wire logic [ADDR_W-1:0] mem_addr,
  output logic mem_word_valid,
  output logic [WORD_W-1:0] mem_word
);
  import ilic_pkg::*;
  logic [ADDR_W-1:0] base_q = 32'h0; // Line being returned
  int left_q = 0; // Words still owed
  int gap_q = 0; // Idle cycles before next word
  initial mem_word_valid = 1'b0;
  initial mem_word = 32'h0;
  // whole line, word 0 first; bus shows garbage between words
  always @(posedge clock) begin
    if (!rst && mem_req == 1'b0 && left_q > 0 && gap_q == 0) begin
      mem_word_valid <= 1'b1;
      mem_word <= (base_q | ((8 - left_q) << 2)) ^ 32'h5A5A5A5A;
      left_q <= left_q - 1;
      gap_q <= slow ? 3 : 0;
    end else begin
      mem_word_valid <= 1'b0;
      mem_word <= ~mem_word;
      if (rst) left_q <= 0;
      else if (mem_req) begin
        base_q <= mem_addr;
        left_q <= 8;
        gap_q <= 2;
      end else if (gap_q > 0) gap_q <= gap_q - 1;
    end
  end
endmodule

// File: verification/icache_lock_invalidate_control_tb_top.sv
// Self-checking bench for the cache control block.
// Assumes the memory model answers every line request.
`timescale 1ns/1ps
module icache_lock_invalidate_control_tb_top;
  import ilic_pkg::*;
  logic clock = 1'b0, rst = 1'b1, ctrl_wr = 1'b0, cmd_valid = 1'b0;
  logic fb_wr_valid = 1'b0, fb_cacheable = 1'b0, slow = 1'b0, got_wr;
  logic [ADDR_W-1:0] ctrl_wdata = '0, cmd_addr = '0, fb_addr = '0;
  logic [ADDR_W-1:0] lookup_addr = '0, mem_addr;
  ilic_cmd_t cmd_code = CMD_INV_ALL;
  logic [LINE_W-1:0] fb_line = '0, got_line, line_wr_data;
  logic cmd_ready, cmd_done, lookup_hit, icache_enable, fetch_buf_flush;
  logic branch_predict_buffer_inv, line_wr_valid, mem_req, mem_word_valid;
  logic [SET_W-1:0] line_wr_set;
  logic [WAY_W-1:0] lookup_way, line_wr_way, got_way;
  logic [WORD_W-1:0] mem_word;
  int mismatches = 0, comparisons = 0;
  int rr[SETS]; // Reference round-robin pointers
  int lk[SETS]; // Reference lock counts
  logic [ADDR_W-1:0] open_q[$], locked_q[$]; // Lines in use
  ilic_top u_dut (.clock(clock), .rst(rst), .ctrl_wr(ctrl_wr),
    .ctrl_wdata(ctrl_wdata), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_addr(cmd_addr), .cmd_ready(cmd_ready), .cmd_done(cmd_done),
    .fb_wr_valid(fb_wr_valid), .fb_cacheable(fb_cacheable),
    .fb_addr(fb_addr), .fb_line(fb_line), .lookup_addr(lookup_addr),
    .lookup_hit(lookup_hit), .lookup_way(lookup_way),
    .icache_enable(icache_enable), .fetch_buf_flush(fetch_buf_flush),
    .branch_predict_buffer_inv(branch_predict_buffer_inv),
    .line_wr_valid(line_wr_valid), .line_wr_set(line_wr_set),
    .line_wr_way(line_wr_way), .line_wr_data(line_wr_data),
    .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_word_valid(mem_word_valid), .mem_word(mem_word));
  ilic_mem_model u_mem (.clock(clock), .rst(rst), .slow(slow),
    .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_word_valid(mem_word_valid), .mem_word(mem_word));
  // ************************************************************
  // Helpers
  // ************************************************************
  always #2.5 clock = ~clock;
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [LINE_W-1:0] e, g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s exp %0h got %0h", nm, e, g);
    end
  endtask
  // Random tag keeps lines of one set apart
  function automatic logic [ADDR_W-1:0] mk(input int s, input int n);
    logic [TAG_W-1:0] t;
    t = {8'(n), 14'($urandom)};
    return {t, 5'(s), 5'h00};
  endfunction
  // Line the memory model returns for an address
  function automatic logic [LINE_W-1:0] ln(input logic [ADDR_W-1:0] a);
    logic [LINE_W-1:0] r;
    for (int i = 0; i < 8; i++)
      r[32*i+:32] = {a[31:5], 3'(i), 2'b00} ^ 32'h5A5A5A5A;
    return r;
  endfunction
  task automatic look(input logic [ADDR_W-1:0] a, input logic h, int w);
    @(negedge clock) lookup_addr = a;
    @(negedge clock);
    chk("hit", h, lookup_hit);
    if (h) chk("way", LINE_W'(w), lookup_way);
  endtask
  task automatic fbw(input logic [ADDR_W-1:0] a, input logic c, e);
    int s;
    s = a[9:5];
    @(negedge clock);
    fb_wr_valid = 1'b1;
    fb_addr = a;
    fb_cacheable = c;
    for (int i = 0; i < 8; i++) fb_line[32*i+:32] = $urandom;
    @(negedge clock) fb_wr_valid = 1'b0;
    chk("wr", e, line_wr_valid);
    if (e) begin
      chk("way", LINE_W'(rr[s]), line_wr_way);
      chk("data", fb_line, line_wr_data);
      rr[s] = (rr[s] == 31) ? lk[s] : rr[s] + 1;
    end
  endtask
  // Hold the request until ready, then wait for done under a bound
  task automatic cmd(input ilic_cmd_t c, input logic [ADDR_W-1:0] a);
    int n;
    logic [1:0] fx;
    @(negedge clock);
    cmd_valid = 1'b1;
    cmd_code = c;
    cmd_addr = a;
    for (n = 0; !cmd_ready && n < 100; n++) @(negedge clock);
    @(negedge clock) cmd_valid = 1'b0;
    for (n = 0; !cmd_done && n < 200; n++) @(negedge clock);
    chk("done", 1'b1, cmd_done);
    // Flush strobes stand only in the done cycle
    fx = {c == CMD_INV_ALL, c == CMD_INV_ALL || c == CMD_INV_LINE};
    chk("flush", fx, {fetch_buf_flush, branch_predict_buffer_inv});
    got_wr = line_wr_valid;
    got_way = line_wr_way;
    got_line = line_wr_data;
  endtask
  task automatic lock(input logic [ADDR_W-1:0] a);
    int s;
    s = a[9:5];
    cmd(CMD_LOCK_LINE, a);
    chk("lwr", 1'b1, got_wr);
    chk("ldata", ln(a), got_line);
    chk("maddr", a, mem_addr);
    if (lk[s] < 28) begin
      chk("lway", LINE_W'(lk[s]), got_way);
      if (rr[s] <= lk[s]) rr[s] = lk[s] + 1;
      lk[s]++;
    end else begin
      chk("full", 1'b1, got_way >= LOCK_MAX);
      chk("uway", LINE_W'(rr[s]), got_way);
      rr[s] = (rr[s] == 31) ? lk[s] : rr[s] + 1;
    end
  endtask
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    void'($urandom(32'h7DFD2BF9));
    foreach (rr[i]) rr[i] = 31;
    foreach (lk[i]) lk[i] = 0;
    repeat (5) @(posedge clock);
    @(negedge clock) rst = 1'b0;
    chk("en", 1'b0, icache_enable);
    look(mk(3, 1), 1'b0, 0);
    // no dirty data cache here, so the invalidate may follow at once
    cmd(CMD_INV_ALL, 32'h0);
    for (int i = 0; i < 2; i++) begin
      @(negedge clock) ctrl_wr = 1'b1;
      ctrl_wdata = $urandom;
      ctrl_wdata[EN_BIT] = i[0];
      @(negedge clock) ctrl_wr = 1'b0;
      chk("en", i[0], icache_enable);
      fbw(mk(3, 9), i == 0, 1'b0);
    end
    for (int i = 0; i < 6; i++) begin
      open_q.push_back(mk(3, i));
      fbw(open_q[i], 1'b1, 1'b1);
    end
    look(open_q[5], 1'b1, 4);
    cmd(CMD_INV_LINE, open_q[2]);
    look(open_q[2], 1'b0, 0);
    look(open_q[3], 1'b1, 2);
    cmd(CMD_INV_ALL, 32'h0);
    look(open_q[3], 1'b0, 0);
    for (int i = 0; i < 29; i++) begin
      slow = i[0];
      locked_q.push_back(mk(7, i));
      lock(locked_q[i]);
    end
    look(locked_q[0], 1'b1, 0);
    look(locked_q[28], 1'b1, 31);
    for (int i = 0; i < 5; i++) fbw(mk(7, 40 + i), 1'b1, 1'b1);
    cmd(CMD_INV_ALL, 32'h0);
    look(locked_q[5], 1'b1, 5);
    cmd(CMD_UNLOCK_ALL, 32'h0);
    foreach (lk[i]) lk[i] = 0;
    look(locked_q[5], 1'b1, 5);
    cmd(CMD_INV_ALL, 32'h0);
    look(locked_q[5], 1'b0, 0);
    // A reset in mid-run drops locked lines and rewinds the pointers
    locked_q.push_back(mk(2, 0));
    lock(locked_q[29]);
    @(negedge clock) rst = 1'b1;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    foreach (rr[i]) rr[i] = 31;
    foreach (lk[i]) lk[i] = 0;
    chk("en", 1'b0, icache_enable);
    look(locked_q[29], 1'b0, 0);
    @(negedge clock) ctrl_wr = 1'b1;
    ctrl_wdata[EN_BIT] = 1'b1;
    @(negedge clock) ctrl_wr = 1'b0;
    fbw(mk(2, 1), 1'b1, 1'b1);
    close_out();
  end
  // Run needs about 900 cycles; cut a hang well past that
  initial begin
    #100000;
    mismatches++;
    close_out();
  end
endmodule
